/* tcci_regs.svh */
`ifndef TCCI_REGS_SVH
`define TCCI_REGS_SVH

// Screen geometry and report offset.
`define TCCI_COLS       11'd80
`define TCCI_LAST_COL   7'd79
`define TCCI_LAST_LINE  5'd23
`define TCCI_LAST_CELL  11'd1919
`define TCCI_SCROLL_END 11'd1840
`define TCCI_POS_OFS    8'h20

// Received and sent character codes.
`define TCCI_BEL   8'h07
`define TCCI_BS    8'h08
`define TCCI_HT    8'h09
`define TCCI_LF    8'h0a
`define TCCI_VT    8'h0b
`define TCCI_FF    8'h0c
`define TCCI_CR    8'h0d
`define TCCI_SO    8'h0e
`define TCCI_SI    8'h0f
`define TCCI_ESC   8'h1b
`define TCCI_FS    8'h1c
`define TCCI_GS    8'h1d
`define TCCI_US    8'h1f
`define TCCI_SPACE 8'h20
`define TCCI_CAP_O 8'h4f
`define TCCI_RBRK  8'h5d

// Busy timing.
`define TCCI_CLK_KHZ      50000
`define TCCI_BUSY_SLOW_MS 500
`define TCCI_BUSY_FAST_MS 60

`endif

/* tcci_pkg.sv */
package tcci_pkg;

	typedef enum logic [1:0]
	{
		TAG_NORMAL = 2'b00,
		TAG_FAC    = 2'b01,
		TAG_ALT    = 2'b10,
		TAG_BAD    = 2'b11
	} tcci_tag_t;

	typedef struct packed
	{
		tcci_tag_t  tag;
		logic [6:0] code;
	} tcci_cell_t;

	typedef enum logic [3:0]
	{
		S_CLEAR,
		S_IDLE,
		S_WAITCOPY,
		S_RPT,
		S_ERASE,
		S_SEND,
		S_TABF,
		S_TABB,
		S_SCROLL
	} tcci_state_t;

	typedef struct packed
	{
		tcci_state_t state;
		logic        rdy;
		logic        armed;
		logic        fac_next;
		logic [1:0]  addr_ph;
		logic [6:0]  addr_x;
		logic [6:0]  col;
		logic [4:0]  line;
		logic        alt;
		logic        has_fac;
		logic        copy_busy;
		logic        copy_start;
		logic [10:0] scan;
		logic [2:0]  step;
		logic        prot;
		logic        xmit;
		logic        all_mode;
		logic [4:0]  last_line;
		logic        tx_valid;
		logic [7:0]  tx_data;
		logic        busy_start;
		logic        busy_n;
	} tcci_ctl_t;

	typedef struct packed
	{
		logic [24:0] cnt;
		logic        busy;
	} tcci_tmr_t;

endpackage

/* tcci_busy_timer.sv */
`timescale 1ns/100ps
`default_nettype none

module tcci_busy_timer
	import tcci_pkg::*;
#(
	parameter int SLOW_CYC = 25000000,
	parameter int FAST_CYC = 3000000
)
(
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst,
	// Control.
	input  wire logic start,
	input  wire logic fast,
	// Status.
	output logic      busy
);

	tcci_tmr_t t_reg;
	tcci_tmr_t t_next;

	// A start reloads the count; busy stays high while it runs down.
	always_comb
	begin
		t_next = t_reg;
		if (start)
			t_next.cnt = fast ? 25'(FAST_CYC) : 25'(SLOW_CYC);
		else if (t_reg.cnt != 25'h0)
			t_next.cnt = t_reg.cnt - 25'h1;
		t_next.busy = (t_next.cnt != 25'h0);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			t_reg <= '0;
		else
			t_reg <= t_next;
	end

	assign busy = t_reg.busy;

endmodule

`default_nettype wire

/* tcci_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "tcci_regs.svh"

// Operation
// - Escape then right bracket sends GS, column code, line code, terminator.
// - Column code is column plus 32; line code is line plus 32.
// - Last report byte is the strap-selected terminator, usually CR.
// - Advancing past column 79 does carriage return plus line feed.
// - Backspace moves one column left; nothing at the left margin.
// - Tab goes past next unprotected attribute or home; else one right.
// - Line feed moves down, optional CR strap; past last line scrolls.
// - Vertical tab goes back to previous input field or home; direct ignores.
// - CR goes to column zero, optional LF; with KBD_STORE it is stored.
// - Shift-out selects the rulings set; shift-in returns to standard.
// - Escape arms the decoder so the next byte is a command.
// - The byte after escape drives host busy for 0.5 s or 60 ms.
// - File separator enters cursor addressing using two address bytes.
// - Unit separator makes the next byte a field attribute code.
// - Buffer sends put a unit separator before each attribute code.
// - Escape bell starts a copy; cursor reads wait for its end.
// - Escape form feed clears screen, homes cursor, resets control state.
// - Escape shift-out sends every field from start to end of text.
// - After a page send the cursor sits at column zero, on the line of the last byte sent.
// - Escape shift-in sends transmittable fields only, never rulings.
// - Escape capital O nulls unprotected data, keeps rulings and attributes.
// - Stored cells tag seven data bits: normal, attribute, alternate, invalid.
module tcci_top
	import tcci_pkg::*;
#(
	parameter int BUSY_SLOW_CYC = `TCCI_BUSY_SLOW_MS * `TCCI_CLK_KHZ,
	parameter int BUSY_FAST_CYC = `TCCI_BUSY_FAST_MS * `TCCI_CLK_KHZ
)
(
	// Clock and reset.
	input  wire logic       CLK_SYS,
	input  wire logic       RESET,
	// Received byte stream.
	input  wire logic [7:0] RX_DATA,
	input  wire logic       RX_VALID,
	input  wire logic       KBD_STORE,
	output logic            RX_READY,
	// Transmitted byte stream.
	output logic [7:0]      TX_DATA,
	output logic            TX_VALID,
	input  wire logic       TX_READY,
	// Straps and mode.
	input  wire logic       BUFFER_MODE,
	input  wire logic       STRAP_LF_DOES_CR,
	input  wire logic       STRAP_CR_DOES_LF,
	input  wire logic       STRAP_FAST,
	input  wire logic [7:0] STRAP_END_CHAR,
	// Hard copy unit.
	output logic            COPY_START,
	input  wire logic       COPY_DONE,
	// Status.
	output logic            HOST_SIDE_BUSY_N,
	output logic [6:0]      CURSOR_COL,
	output logic [4:0]      CURSOR_LINE,
	output logic            ALT_SET
);

	tcci_ctl_t  st_reg;
	tcci_ctl_t  st_next;
	tcci_cell_t mem [0:2047];
	tcci_cell_t rd;
	tcci_cell_t wdata;
	logic       we;
	logic [10:0] waddr;
	logic [10:0] raddr;
	logic [10:0] cur;
	logic       acc;
	logic       plain;
	logic       tmr_busy;
	logic [7:0] d;

	function automatic logic [11:0] f_pos(input logic [10:0] a);
		f_pos = {5'(a / `TCCI_COLS), 7'(a % `TCCI_COLS)};
	endfunction

	function automatic tcci_ctl_t f_lf(input tcci_ctl_t s);
		f_lf = s;
		if (s.line == `TCCI_LAST_LINE)
		begin
			f_lf.state = S_SCROLL;
			f_lf.scan = 11'h0;
		end
		else
			f_lf.line = s.line + 5'h1;
	endfunction

	function automatic tcci_ctl_t f_adv(input tcci_ctl_t s);
		f_adv = s;
		if (s.col == `TCCI_LAST_COL)
		begin
			f_adv.col = 7'h0;
			f_adv = f_lf(f_adv);
		end
		else
			f_adv.col = s.col + 7'h1;
	endfunction

	assign d = RX_DATA;
	assign acc = RX_VALID && st_reg.rdy;
	assign plain = acc && !st_reg.armed && !st_reg.fac_next &&
		(st_reg.addr_ph == 2'h0);
	assign cur = 11'(st_reg.line) * `TCCI_COLS + 11'(st_reg.col);
	assign rd = mem[raddr];

	tcci_busy_timer #(
		.SLOW_CYC(BUSY_SLOW_CYC),
		.FAST_CYC(BUSY_FAST_CYC)
	) u_busy (
		.clk  (CLK_SYS),
		.rst  (RESET),
		.start(st_reg.busy_start),
		.fast (STRAP_FAST),
		.busy (tmr_busy)
	);

	always_comb
	begin
		st_next = st_reg;
		we = 1'b0;
		waddr = cur;
		wdata = '0;
		raddr = st_reg.scan;
		st_next.copy_start = 1'b0;
		st_next.busy_start = 1'b0;
		st_next.busy_n = !tmr_busy;
		if (st_reg.copy_busy && COPY_DONE)
			st_next.copy_busy = 1'b0;
		if (st_reg.tx_valid && TX_READY)
			st_next.tx_valid = 1'b0;
		unique case (st_reg.state)
			S_CLEAR:
			begin
				we = 1'b1;
				waddr = st_reg.scan;
				st_next.scan = st_reg.scan + 11'h1;
				if (st_reg.scan == `TCCI_LAST_CELL)
					st_next.state = S_IDLE;
			end
			S_IDLE:
			begin
				if (acc && st_reg.armed)
				begin
					st_next.armed = 1'b0;
					st_next.busy_start = 1'b1;
					if (d == `TCCI_BEL)
					begin
						st_next.copy_start = 1'b1;
						st_next.copy_busy = 1'b1;
					end
					else if (d == `TCCI_RBRK)
					begin
						st_next.step = 3'h0;
						st_next.state = st_reg.copy_busy ? S_WAITCOPY : S_RPT;
					end
					else if (d == `TCCI_FF)
					begin
						st_next.state = S_CLEAR;
						st_next.scan = 11'h0;
						st_next.col = 7'h0;
						st_next.line = 5'h0;
						st_next.alt = 1'b0;
						st_next.has_fac = 1'b0;
					end
					else if (d == `TCCI_SO || d == `TCCI_SI)
					begin
						st_next.state = S_SEND;
						st_next.all_mode = (d == `TCCI_SO);
						st_next.scan = 11'h0;
						st_next.step = 3'h0;
						st_next.xmit = 1'b1;
						st_next.last_line = 5'h0;
					end
					else if (d == `TCCI_CAP_O)
					begin
						st_next.state = S_ERASE;
						st_next.scan = 11'h0;
						st_next.prot = 1'b0;
						st_next.col = 7'h0;
						st_next.line = 5'h0;
					end
				end
				else if (acc && st_reg.fac_next)
				begin
					st_next.fac_next = 1'b0;
					we = 1'b1;
					wdata = {TAG_FAC, d[6:0]};
					st_next.has_fac = 1'b1;
					st_next = f_adv(st_next);
				end
				else if (acc && st_reg.addr_ph == 2'h1)
				begin
					st_next.addr_x = 7'(d - `TCCI_POS_OFS);
					if (d - `TCCI_POS_OFS > 8'(`TCCI_LAST_COL))
						st_next.addr_x = `TCCI_LAST_COL;
					st_next.addr_ph = 2'h2;
				end
				else if (acc && st_reg.addr_ph == 2'h2)
				begin
					st_next.col = st_reg.addr_x;
					st_next.line = 5'(d - `TCCI_POS_OFS);
					if (d - `TCCI_POS_OFS > 8'(`TCCI_LAST_LINE))
						st_next.line = `TCCI_LAST_LINE;
					st_next.addr_ph = 2'h0;
				end
				else if (plain)
				begin
					unique case (d)
						`TCCI_ESC:
							st_next.armed = 1'b1;
						`TCCI_BS:
							if (st_reg.col != 7'h0)
								st_next.col = st_reg.col - 7'h1;
						`TCCI_HT:
							if (BUFFER_MODE && st_reg.has_fac)
							begin
								if (cur == `TCCI_LAST_CELL)
									{st_next.line, st_next.col} = 12'h0;
								else
								begin
									st_next.scan = cur + 11'h1;
									st_next.state = S_TABF;
								end
							end
							else
								st_next = f_adv(st_next);
						`TCCI_LF:
						begin
							if (STRAP_LF_DOES_CR)
								st_next.col = 7'h0;
							st_next = f_lf(st_next);
						end
						`TCCI_VT:
							if (BUFFER_MODE)
							begin
								if (cur < 11'h2 || !st_reg.has_fac)
									{st_next.line, st_next.col} = 12'h0;
								else
								begin
									st_next.scan = cur - 11'h2;
									st_next.state = S_TABB;
								end
							end
						`TCCI_CR:
							if (KBD_STORE)
							begin
								we = 1'b1;
								wdata = {TAG_NORMAL, d[6:0]};
								st_next = f_adv(st_next);
							end
							else
							begin
								st_next.col = 7'h0;
								if (STRAP_CR_DOES_LF)
									st_next = f_lf(st_next);
							end
						`TCCI_SO:
							st_next.alt = 1'b1;
						`TCCI_SI:
							st_next.alt = 1'b0;
						`TCCI_FS:
							st_next.addr_ph = 2'h1;
						`TCCI_US:
							st_next.fac_next = 1'b1;
						default:
							if (d >= `TCCI_SPACE)
							begin
								we = 1'b1;
								wdata = {st_reg.alt ? TAG_ALT : TAG_NORMAL, d[6:0]};
								st_next = f_adv(st_next);
							end
					endcase
				end
			end
			S_WAITCOPY:
				if (!st_reg.copy_busy)
					st_next.state = S_RPT;
			S_RPT:
				if (!st_reg.tx_valid || TX_READY)
				begin
					if (st_reg.step == 3'h4)
						st_next.state = S_IDLE;
					else
					begin
						st_next.tx_valid = 1'b1;
						st_next.step = st_reg.step + 3'h1;
						unique case (st_reg.step)
							3'h0: st_next.tx_data = `TCCI_GS;
							3'h1: st_next.tx_data = {1'b0, st_reg.col} + `TCCI_POS_OFS;
							3'h2: st_next.tx_data = {3'h0, st_reg.line} + `TCCI_POS_OFS;
							default: st_next.tx_data = STRAP_END_CHAR;
						endcase
					end
				end
			S_ERASE:
			begin
				waddr = st_reg.scan;
				if (rd.tag == TAG_FAC)
					st_next.prot = rd.code[1];
				else if (rd.tag == TAG_NORMAL && !st_reg.prot)
					we = 1'b1;
				st_next.scan = st_reg.scan + 11'h1;
				if (st_reg.scan == `TCCI_LAST_CELL)
					st_next.state = S_IDLE;
			end
			S_SEND:
				if (!st_reg.tx_valid || TX_READY)
				begin
					if (st_reg.step == 3'h1)
					begin
						st_next.tx_valid = 1'b1;
						st_next.tx_data = {1'b0, rd.code};
						st_next.step = 3'h0;
					end
					else if (rd.tag == TAG_FAC)
					begin
						st_next.xmit = !rd.code[2];
						if (st_reg.all_mode || !rd.code[2])
						begin
							st_next.tx_valid = 1'b1;
							st_next.tx_data = `TCCI_US;
							st_next.step = 3'h1;
							st_next.last_line = 5'(st_reg.scan / `TCCI_COLS);
						end
					end
					else if (rd != '0 && (st_reg.all_mode ||
						(rd.tag == TAG_NORMAL && st_reg.xmit)))
					begin
						st_next.tx_valid = 1'b1;
						st_next.tx_data = {1'b0, rd.code};
						st_next.last_line = 5'(st_reg.scan / `TCCI_COLS);
					end
					if (st_next.step == 3'h0)
					begin
						st_next.scan = st_reg.scan + 11'h1;
						if (st_reg.scan == `TCCI_LAST_CELL)
						begin
							st_next.state = S_IDLE;
							st_next.col = 7'h0;
							st_next.line = st_next.last_line;
						end
					end
				end
			S_TABF:
				if (rd.tag == TAG_FAC && !rd.code[1])
				begin
					st_next.state = S_IDLE;
					{st_next.line, st_next.col} = (st_reg.scan == `TCCI_LAST_CELL)
						? 12'h0 : f_pos(st_reg.scan + 11'h1);
				end
				else if (st_reg.scan == `TCCI_LAST_CELL)
				begin
					st_next.state = S_IDLE;
					{st_next.line, st_next.col} = 12'h0;
				end
				else
					st_next.scan = st_reg.scan + 11'h1;
			S_TABB:
				if (rd.tag == TAG_FAC && !rd.code[1])
				begin
					st_next.state = S_IDLE;
					{st_next.line, st_next.col} = f_pos(st_reg.scan + 11'h1);
				end
				else if (st_reg.scan == 11'h0)
				begin
					st_next.state = S_IDLE;
					{st_next.line, st_next.col} = 12'h0;
				end
				else
					st_next.scan = st_reg.scan - 11'h1;
			S_SCROLL:
			begin
				raddr = st_reg.scan + 11'(`TCCI_COLS);
				we = 1'b1;
				waddr = st_reg.scan;
				wdata = (st_reg.scan < `TCCI_SCROLL_END) ? rd : '0;
				st_next.scan = st_reg.scan + 11'h1;
				if (st_reg.scan == `TCCI_LAST_CELL)
					st_next.state = S_IDLE;
			end
		endcase
		st_next.rdy = (st_next.state == S_IDLE);
	end

	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			st_reg <= '0;
			st_reg.busy_n <= 1'b1;
		end
		else
			st_reg <= st_next;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	assign RX_READY = st_reg.rdy;
	assign TX_DATA = st_reg.tx_data;
	assign TX_VALID = st_reg.tx_valid;
	assign COPY_START = st_reg.copy_start;
	assign HOST_SIDE_BUSY_N = st_reg.busy_n;
	assign CURSOR_COL = st_reg.col;
	assign CURSOR_LINE = st_reg.line;
	assign ALT_SET = st_reg.alt;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RESET);

	property p_rpt_gs;
		st_reg.state == S_RPT && st_reg.tx_valid && st_reg.step == 3'h1
			|-> st_reg.tx_data == `TCCI_GS;
	endproperty
	a_rpt_gs: assert property (p_rpt_gs) else $error("bad report lead");

	property p_rpt_col;
		st_reg.state == S_RPT && st_reg.tx_valid && st_reg.step == 3'h2
			|-> st_reg.tx_data == {1'b0, st_reg.col} + 8'h20;
	endproperty
	a_rpt_col: assert property (p_rpt_col) else $error("bad column code");

	property p_rpt_end;
		st_reg.state == S_RPT && st_reg.tx_valid && st_reg.step == 3'h4
			|-> st_reg.tx_data == STRAP_END_CHAR;
	endproperty
	a_rpt_end: assert property (p_rpt_end) else $error("bad terminator");

	property p_wrap;
		plain && d >= 8'h20 && st_reg.col == 7'd79 |=> st_reg.col == 7'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap at line end");

	property p_bs;
		plain && d == 8'h08 |=> st_reg.col ==
			($past(st_reg.col) == 7'h0 ? 7'h0 : $past(st_reg.col) - 7'h1);
	endproperty
	a_bs: assert property (p_bs) else $error("backspace wrong");

	property p_so;
		plain && d == 8'h0e |=> ALT_SET;
	endproperty
	a_so: assert property (p_so) else $error("rulings set not selected");

	property p_esc;
		plain && d == 8'h1b |=> st_reg.armed ##1 !st_reg.busy_start;
	endproperty
	a_esc: assert property (p_esc) else $error("escape did not arm");

	property p_busy;
		acc && st_reg.armed |-> ##3 !HOST_SIDE_BUSY_N;
	endproperty
	a_busy: assert property (p_busy) else $error("busy not raised");

	property p_copy_wait;
		acc && st_reg.armed && d == 8'h5d && st_reg.copy_busy && !COPY_DONE
			|=> st_reg.state == S_WAITCOPY && !TX_VALID;
	endproperty
	a_copy_wait: assert property (p_copy_wait) else $error("read during copy");

	property p_tag;
		we |-> wdata.tag != TAG_BAD;
	endproperty
	a_tag: assert property (p_tag) else $error("invalid tag stored");

endmodule

`default_nettype wire

/* tcci_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module tcci_host_model
(
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       rst,
	// Byte stream from the terminal.
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	// Pacing.
	input  wire logic       slow
);
	logic [7:0] got_q[$];
	logic [1:0] pace_reg = 2'h0;

	// Ready moves at the falling edge; slow pacing is ready one cycle in three.
	always @(negedge clk)
	begin
		pace_reg <= (pace_reg == 2'h2) ? 2'h0 : pace_reg + 2'h1;
		tx_ready <= !rst && (!slow || pace_reg == 2'h2);
	end

	// A byte is taken at the rising edge where valid meets ready.
	always @(posedge clk)
		if (!rst && tx_valid === 1'b1 && tx_ready)
			got_q.push_back(tx_data);
endmodule

`default_nettype wire

/* tb_tcci_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_tcci_top;
	localparam int SLOW = 20;
	localparam int FAST = 8;
	// Design ports.
	logic       CLK_SYS;
	logic       RESET;
	logic [7:0] RX_DATA;
	logic       RX_VALID;
	logic       KBD_STORE;
	logic       RX_READY;
	logic [7:0] TX_DATA;
	logic       TX_VALID;
	logic       TX_READY;
	logic       BUFFER_MODE;
	logic       STRAP_LF_DOES_CR;
	logic       STRAP_CR_DOES_LF;
	logic       STRAP_FAST;
	logic [7:0] STRAP_END_CHAR;
	logic       COPY_START;
	logic       COPY_DONE;
	logic       HOST_SIDE_BUSY_N;
	logic [6:0] CURSOR_COL;
	logic [4:0] CURSOR_LINE;
	logic       ALT_SET;
	// Bench state.
	logic       host_slow;
	logic [7:0] exp_q[$];
	int         failures;
	int         total_checks;
	int         copies = 0;

	tcci_top #(.BUSY_SLOW_CYC(SLOW), .BUSY_FAST_CYC(FAST)) dut_u
	(
		.CLK_SYS(CLK_SYS), .RESET(RESET), .RX_DATA(RX_DATA),
		.RX_VALID(RX_VALID), .KBD_STORE(KBD_STORE), .RX_READY(RX_READY),
		.TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
		.BUFFER_MODE(BUFFER_MODE), .STRAP_LF_DOES_CR(STRAP_LF_DOES_CR),
		.STRAP_CR_DOES_LF(STRAP_CR_DOES_LF), .STRAP_FAST(STRAP_FAST),
		.STRAP_END_CHAR(STRAP_END_CHAR), .COPY_START(COPY_START),
		.COPY_DONE(COPY_DONE), .HOST_SIDE_BUSY_N(HOST_SIDE_BUSY_N),
		.CURSOR_COL(CURSOR_COL), .CURSOR_LINE(CURSOR_LINE),
		.ALT_SET(ALT_SET)
	);

	tcci_host_model host_u
	(
		.clk(CLK_SYS), .rst(RESET), .tx_data(TX_DATA),
		.tx_valid(TX_VALID), .tx_ready(TX_READY), .slow(host_slow)
	);

	initial
	begin
		CLK_SYS = 1'b0;
		forever
			#10 CLK_SYS = ~CLK_SYS;
	end

	always @(negedge CLK_SYS)
		if (COPY_START === 1'b1)
			copies++;

	task automatic give_verdict;
		$display("failures=%0d total_checks=%0d", failures, total_checks);
		if (failures == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic timeout(input string what);
		failures++;
		$display("MISMATCH %0t timeout %s", $time, what);
		give_verdict;
	endtask

	task automatic check8(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wait_ready;
		int k;
		for (k = 0; k < 8000 && RX_READY !== 1'b1; k++)
			@(negedge CLK_SYS);
		if (k == 8000)
			timeout("ready");
	endtask

	// Offer one byte and hold it until the edge that takes it.
	task automatic sb(input logic [7:0] b);
		@(negedge CLK_SYS);
		RX_DATA = b;
		RX_VALID = 1'b1;
		wait_ready;
		@(negedge CLK_SYS);
		RX_VALID = 1'b0;
	endtask

	task automatic ss(input logic [7:0] s[$]);
		foreach (s[i])
			sb(s[i]);
	endtask

	task automatic go(input logic [7:0] c, input logic [7:0] l);
		ss({8'h1c, c + 8'h20, l + 8'h20});
	endtask

	task automatic check_pos(input logic [7:0] c, input logic [7:0] l);
		wait_ready;
		check8({1'b0, CURSOR_COL}, c, "column");
		check8({3'h0, CURSOR_LINE}, l, "line");
	endtask

	// Compare the bytes the host collected, then forget them.
	task automatic check_q(input logic [7:0] e[$]);
		int k;
		for (k = 0; k < 9000 && host_u.got_q.size() < e.size(); k++)
			@(negedge CLK_SYS);
		if (k == 9000)
			timeout("bytes");
		repeat (8)
			@(negedge CLK_SYS);
		check8(8'(host_u.got_q.size()), 8'(e.size()), "byte count");
		foreach (e[i])
			if (i < host_u.got_q.size())
				check8(host_u.got_q[i], e[i], "sent byte");
		host_u.got_q.delete();
	endtask

	// Measure the busy pulse started by the byte after escape.
	task automatic busy_len(input int exp);
		int k;
		for (k = 0; k < 200 && HOST_SIDE_BUSY_N !== 1'b1; k++)
			@(negedge CLK_SYS);
		if (k == 200)
			timeout("busy idle");
		ss({8'h1b, 8'h0d});
		for (k = 0; k < 8 && HOST_SIDE_BUSY_N !== 1'b0; k++)
			@(negedge CLK_SYS);
		if (k == 8)
			timeout("busy start");
		for (k = 0; k < 200 && HOST_SIDE_BUSY_N === 1'b0; k++)
			@(negedge CLK_SYS);
		if (k == 200)
			timeout("busy end");
		check8(8'(k), 8'(exp), "busy length");
	endtask

	initial
	begin
		#2000000;
		timeout("watchdog");
	end

	initial
	begin
		failures = 0;
		total_checks = 0;
		RESET = 1'b1;
		RX_DATA = 8'h00;
		RX_VALID = 1'b0;
		KBD_STORE = 1'b0;
		BUFFER_MODE = 1'b1;
		STRAP_LF_DOES_CR = 1'b0;
		STRAP_CR_DOES_LF = 1'b0;
		STRAP_FAST = 1'b0;
		STRAP_END_CHAR = 8'h0d;
		COPY_DONE = 1'b0;
		host_slow = 1'b0;
		repeat (2)
			@(negedge CLK_SYS);
		check8({7'h0, HOST_SIDE_BUSY_N}, 8'h01, "reset busy");
		check8({6'h0, TX_VALID, ALT_SET}, 8'h00, "reset flags");
		RESET = 1'b0;
		check_pos(8'h00, 8'h00);
		go(8'h05, 8'h03);
		check_pos(8'h05, 8'h03);
		sb(8'h08);
		check_pos(8'h04, 8'h03);
		sb(8'h09);
		check_pos(8'h05, 8'h03);
		sb(8'h0d);
		check_pos(8'h00, 8'h03);
		sb(8'h08);
		check_pos(8'h00, 8'h03);
		go(8'h07, 8'h04);
		sb(8'h0a);
		check_pos(8'h07, 8'h05);
		STRAP_LF_DOES_CR = 1'b1;
		sb(8'h0a);
		check_pos(8'h00, 8'h06);
		STRAP_LF_DOES_CR = 1'b0;
		STRAP_CR_DOES_LF = 1'b1;
		go(8'h09, 8'h06);
		sb(8'h0d);
		check_pos(8'h00, 8'h07);
		STRAP_CR_DOES_LF = 1'b0;
		KBD_STORE = 1'b1;
		sb(8'h0d);
		check_pos(8'h01, 8'h07);
		KBD_STORE = 1'b0;
		go(8'h4f, 8'h02);
		sb(8'h41);
		check_pos(8'h00, 8'h03);
		go(8'h4f, 8'h17);
		sb(8'h41);
		check_pos(8'h00, 8'h17);
		sb(8'h0a);
		check_pos(8'h00, 8'h17);
		go(8'h06, 8'h01);
		ss({8'h1b, 8'h0d});
		check_pos(8'h06, 8'h01);
		sb(8'h0e);
		check8({7'h0, ALT_SET}, 8'h01, "rulings set");
		sb(8'h0f);
		check8({7'h0, ALT_SET}, 8'h00, "standard set");
		busy_len(SLOW);
		STRAP_FAST = 1'b1;
		busy_len(FAST);
		STRAP_FAST = 1'b0;
		host_slow = 1'b1;
		go(8'h11, 8'h09);
		ss({8'h1b, 8'h5d});
		check_q({8'h1d, 8'h31, 8'h29, 8'h0d});
		STRAP_END_CHAR = 8'h03;
		go(8'h4f, 8'h17);
		ss({8'h1b, 8'h5d});
		check_q({8'h1d, 8'h6f, 8'h37, 8'h03});
		ss({8'h1b, 8'h07});
		repeat (2)
			@(negedge CLK_SYS);
		check8(8'(copies), 8'h01, "copy pulses");
		ss({8'h1b, 8'h5d});
		repeat (40)
			@(negedge CLK_SYS);
		check8(8'(host_u.got_q.size()), 8'h00, "early report");
		COPY_DONE = 1'b1;
		@(negedge CLK_SYS);
		COPY_DONE = 1'b0;
		check_q({8'h1d, 8'h6f, 8'h37, 8'h03});
		ss({8'h1b, 8'h0c});
		check_pos(8'h00, 8'h00);
		go(8'h00, 8'h02);
		ss({8'h41, 8'h0e, 8'h52, 8'h0f, 8'h1f, 8'h40, 8'h42});
		ss({8'h1f, 8'h44, 8'h43, 8'h1b, 8'h0e});
		exp_q = {8'h41, 8'h52, 8'h1f, 8'h40, 8'h42, 8'h1f, 8'h44, 8'h43};
		check_q(exp_q);
		check_pos(8'h00, 8'h02);
		ss({8'h1b, 8'h0f});
		check_q({8'h41, 8'h1f, 8'h40, 8'h42});
		check_pos(8'h00, 8'h02);
		sb(8'h09);
		check_pos(8'h03, 8'h02);
		sb(8'h09);
		check_pos(8'h05, 8'h02);
		sb(8'h0b);
		check_pos(8'h03, 8'h02);
		ss({8'h09, 8'h09});
		check_pos(8'h00, 8'h00);
		BUFFER_MODE = 1'b0;
		go(8'h05, 8'h02);
		sb(8'h0b);
		check_pos(8'h05, 8'h02);
		BUFFER_MODE = 1'b1;
		ss({8'h1b, 8'h0c, 8'h1b, 8'h0e});
		check_pos(8'h00, 8'h00);
		check8(8'(host_u.got_q.size()), 8'h00, "after clear");
		ss({8'h41, 8'h42, 8'h1b, 8'h4f, 8'h1b, 8'h0e});
		check_pos(8'h00, 8'h00);
		check8(8'(host_u.got_q.size()), 8'h00, "after erase");
		ss({8'h0e, 8'h52, 8'h0f, 8'h1b, 8'h4f, 8'h1b, 8'h0e});
		check_q({8'h52});
		check_pos(8'h00, 8'h00);
		give_verdict;
	end
endmodule

`default_nettype wire
